// ===== data_transfer_instr_timing_tb_top.sv
// Self-checking bench for the data transfer execution unit
`timescale 1ns/1ns
`define CHECK(nm, got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
	$display("wrong value %s expected %h seen %h", nm, exp, got); end end
module data_transfer_instr_timing_tb_top;
	import dtx_pkg::*;
	typedef struct {
		logic [15:0] ip;
		logic [1:0] len;
		logic [2:0] cyc;
		logic ill;
		logic [7:0] acc;
		logic [7:0] sp;
		logic [15:0] ptr16;
	} dtx_note_t;

	logic clk;
	logic rst;
	logic done;
	logic ill;
	logic xwe;
	logic xre;
	logic [15:0] code_addr;
	logic [15:0] xaddr;
	logic [15:0] ptr16;
	logic [15:0] ip;
	logic [23:0] code_data;
	logic [7:0] xwdata;
	logic [7:0] xrdata;
	logic [7:0] acc;
	logic [7:0] sp;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc_cnt = 0;
	int tick = 0;
	bit go = 0;
	dtx_note_t notes [$];
	dtx_note_t nt;
	logic [15:0] bip = 16'h0000;
	logic [7:0] acc_e = 8'h00;
	logic [7:0] sp_e = 8'h07;
	logic [15:0] ptr_e = 16'h0000;
	logic [7:0] k1;
	logic [7:0] k2;
	logic [7:0] k3;
	logic [7:0] m40;
	logic [15:0] p16;

	dtx_core dut (.CLK_I(clk), .RST_I(rst), .CODE_ADDR_O(code_addr), .CODE_DATA_I(code_data),
		.XDATA_ADDR_O(xaddr), .XDATA_WDATA_O(xwdata), .XDATA_WE_O(xwe), .XDATA_RE_O(xre),
		.XDATA_RDATA_I(xrdata), .ACC_O(acc), .SIXTEEN_BIT_POINTER_O(ptr16), .SP_O(sp), .PC_O(ip),
		.INSTR_DONE_O(done), .ILLEGAL_O(ill));

	dtx_mem_model u_mem (.clk_i(clk), .rst_i(rst), .code_addr_i(code_addr),
		.code_data_o(code_data), .xaddr_i(xaddr), .xwdata_i(xwdata), .xwe_i(xwe),
		.xre_i(xre), .xrdata_o(xrdata));

	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction : pat

	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize

	// Place one instruction in code memory and note what it must leave behind
	task automatic e(input int f, input int i, input logic [7:0] b1, input logic [7:0] b2,
		input int len, input int cyc, input logic [7:0] a);
		acc_e = a;
		u_mem.code_mem[bip] = {f[4:0], i[2:0]};
		u_mem.code_mem[bip + 16'h1] = b1;
		u_mem.code_mem[bip + 16'h2] = b2;
		notes.push_back('{bip, len[1:0], cyc[2:0], f == 28, acc_e, sp_e, ptr_e});
		bip = bip + 16'(len);
	endtask : e

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Watcher: at each completion take the oldest note and compare
	initial begin
		forever begin
			@(negedge clk);
			if (go && notes.size() > 0) begin
				cyc_cnt++;
				if (done === 1'b1) begin
					nt = notes.pop_front();
					`CHECK("cycles", cyc_cnt, int'(nt.cyc))
					`CHECK("current ip", ip, nt.ip)
					`CHECK("illegal flag", ill, nt.ill)
					@(posedge clk);
					#1;
					`CHECK("next ip", ip, nt.ip + 16'(nt.len))
					`CHECK("code addr", code_addr, nt.ip + 16'(nt.len))
					`CHECK("acc", acc, nt.acc)
					`CHECK("stack ptr", sp, nt.sp)
					`CHECK("ptr16", ptr16, nt.ptr16)
					cyc_cnt = 0;
				end
			end
		end
	end

	// Whole program runs in about 120 cycles; a hang ends the run
	always @(posedge clk) begin
		tick++;
		if (tick == 1000) begin
			error_cnt++;
			summarize();
		end
	end

	initial begin
		rst = 1'b1;
		void'($urandom(32'h01d7));
		k1 = 8'($urandom);
		k2 = 8'($urandom);
		k3 = 8'($urandom);
		p16 = {2'h2, 14'($urandom)};
		m40 = {k3[7:4], k1[3:0]};
		#1;
		e(3, 0, k1, 0, 2, 2, k1);
		e(4, 5, 0, 0, 1, 1, k1);
		e(0, 5, 0, 0, 1, 1, k1);
		e(3, 0, k2, 0, 2, 2, k2);
		e(24, 5, 0, 0, 1, 2, k1);
		e(0, 5, 0, 0, 1, 1, k2);
		e(11, 0, 8'h30, k3, 3, 3, k2);
		e(1, 0, 8'h30, 0, 2, 2, k3);
		e(9, 0, 8'h30, 8'h40, 3, 3, k3);
		e(6, 1, 8'h40, 0, 2, 2, k3);
		e(3, 0, k1, 0, 2, 2, k1);
		e(2, 1, 0, 0, 1, 2, k3);
		e(3, 0, k1, 0, 2, 2, k1);
		e(27, 1, 0, 0, 1, 3, {k1[7:4], k3[3:0]});
		e(2, 1, 0, 0, 1, 2, m40);
		e(5, 2, 8'h30, 0, 2, 3, m40);
		e(0, 2, 0, 0, 1, 1, k3);
		e(3, 0, k2, 0, 2, 2, k2);
		e(7, 0, 8'h31, 0, 2, 2, k2);
		e(8, 2, 8'h32, 0, 2, 2, k2);
		e(1, 0, 8'h32, 0, 2, 2, k3);
		e(10, 1, 8'h33, 0, 2, 3, k3);
		e(1, 0, 8'h33, 0, 2, 2, m40);
		e(14, 1, k1, 0, 2, 2, m40);
		e(2, 1, 0, 0, 1, 2, k1);
		e(13, 1, 8'h31, 0, 2, 3, k1);
		e(2, 1, 0, 0, 1, 2, k2);
		e(3, 0, k3, 0, 2, 2, k3);
		e(12, 1, 0, 0, 1, 2, k3);
		e(3, 0, k1, 0, 2, 2, k1);
		e(2, 1, 0, 0, 1, 2, k3);
		e(25, 0, 8'h31, 0, 2, 3, k2);
		e(26, 1, 0, 0, 1, 3, k3);
		e(1, 0, 8'h31, 0, 2, 2, k3);
		e(2, 1, 0, 0, 1, 2, k2);
		sp_e = 8'h08;
		e(22, 0, 8'h30, 0, 2, 3, k2);
		sp_e = 8'h07;
		e(23, 0, 8'h50, 0, 2, 2, k2);
		e(1, 0, 8'h50, 0, 2, 2, k3);
		ptr_e = p16;
		e(15, 0, p16[15:8], p16[7:0], 3, 3, k3);
		e(21, 0, 0, 0, 1, 4, k3);
		e(3, 0, k1, 0, 2, 2, k1);
		e(19, 0, 0, 0, 1, 3, k3);
		e(20, 1, 0, 0, 1, 5, k3);
		e(3, 0, k2, 0, 2, 2, k2);
		e(18, 1, 0, 0, 1, 4, k3);
		e(16, 0, 0, 0, 1, 5, pat(p16 + 16'(k3)));
		e(28, 0, 0, 0, 1, 1, acc_e);
		e(3, 0, 8'hc0, 0, 2, 2, 8'hc0);
		e(17, 0, 0, 0, 1, 4, pat(bip + 16'h00c1));
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		go = 1'b1;
		while (notes.size() > 0) begin
			@(posedge clk);
		end
		repeat (2) @(posedge clk);
		summarize();
	end
endmodule : data_transfer_instr_timing_tb_top

// ===== dtx_core.sv
// Data transfer execution unit of the 8-bit accumulator core
// What this block does
// RULE1: Acc from bank_register: one byte, one cycle
// RULE2: Acc from direct byte: two bytes, two cycles
// RULE3: Acc from pointer RAM: one byte, two cycles
// RULE4: Acc from immediate: two bytes, two cycles
// RULE5: Acc to bank_register: one byte, one cycle
// RULE6: Direct to bank_register: two bytes, three cycles
// RULE7: Immediate to bank_register: two bytes, two cycles
// RULE8: Acc to direct byte: two bytes, two cycles
// RULE9: Bank_register to direct: two bytes, two cycles
// RULE10: Direct to direct: three bytes, three cycles
// RULE11: Pointer RAM to direct: two bytes, three cycles
// RULE12: Immediate to direct: three bytes, three cycles
// RULE13: Acc to pointer RAM: one byte, two cycles
// RULE14: Direct to pointer RAM: two bytes, three cycles
// RULE15: Immediate to pointer RAM: two bytes, two cycles
// RULE16: Load sixteen_bit_pointer: three bytes, three cycles
// RULE17: Code fetch: pointer five cycles, instruction_pointer four
// RULE18: External read: pointer_register four, sixteen_bit three
// RULE19: External write: pointer_register five, sixteen_bit four
// RULE20: Push three cycles, pop two, two bytes
// RULE21: Swap forms: register 1/2, direct 2/3, pointer 1/3
// RULE22: Nibble swap: low digit only, one byte, three
// RULE23: Each instruction completes before the next begins
// RULE24: Push increments first; pop reads then decrements
`timescale 1ns/1ns
module dtx_core (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// Code memory: three bytes from CODE_ADDR_O upward, lowest first
	output logic [15:0] CODE_ADDR_O,
	input wire logic [23:0] CODE_DATA_I,
	// External data memory
	output logic [15:0] XDATA_ADDR_O,
	output logic [7:0] XDATA_WDATA_O,
	output logic XDATA_WE_O,
	output logic XDATA_RE_O,
	input wire logic [7:0] XDATA_RDATA_I,
	// Core state
	output logic [7:0] ACC_O,
	output logic [15:0] SIXTEEN_BIT_POINTER_O,
	output logic [7:0] SP_O,
	output logic [15:0] PC_O,
	output logic INSTR_DONE_O,
	output logic ILLEGAL_O
);
	import dtx_pkg::*;

	dtx_state_t state_r;
	logic [2:0] cnt_r;
	dtx_form_t form_r;
	logic [2:0] idx_r;
	logic [1:0] len_r;
	logic [2:0] cyc_r;
	logic [7:0] b1_r;
	logic [7:0] b2_r;
	logic [7:0] acc_r;
	logic [7:0] acc_nxt;
	logic [15:0] sixteen_bit_pointer_r;
	logic [7:0] sp_r;
	logic [15:0] pc_r;
	logic [15:0] code_addr_r;
	logic [15:0] xaddr_r;
	logic [7:0] xwdata_r;
	logic [7:0] rn_r [NUM_BANK];
	logic [7:0] rn_nxt;

	dtx_form_t dec_form;
	logic [2:0] dec_idx;
	logic [1:0] dec_len;
	logic [2:0] dec_cyc;
	logic dec_legal;

	dtx_form_t cur_form;
	logic [2:0] cur_idx;
	logic [1:0] cur_len;
	logic [2:0] cur_cyc;
	logic [7:0] cur_b1;
	logic [7:0] cur_b2;
	logic start;
	logic done;
	logic [7:0] ri_val;
	logic [7:0] rn_val;
	logic acc_we;
	logic rn_we;

	logic ram_re;
	logic [7:0] ram_raddr;
	logic [7:0] ram_rdata;
	logic ram_we;
	logic [7:0] ram_waddr;
	logic [7:0] ram_wdata;

	dtx_decode u_decode (
		.opcode_i(CODE_DATA_I[7:0]),
		.form_o(dec_form),
		.idx_o(dec_idx),
		.len_o(dec_len),
		.cyc_o(dec_cyc),
		.legal_o(dec_legal)
	);

	dtx_ram u_ram (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.re_i(ram_re),
		.raddr_i(ram_raddr),
		.rdata_o(ram_rdata),
		.we_i(ram_we),
		.waddr_i(ram_waddr),
		.wdata_i(ram_wdata)
	);

	// The first cycle works from the fresh opcode, later ones from the latch
	assign start = (state_r == ST_DECODE);
	assign cur_form = start ? dec_form : form_r;
	assign cur_idx = start ? dec_idx : idx_r;
	assign cur_len = start ? dec_len : len_r;
	assign cur_cyc = start ? dec_cyc : cyc_r;
	assign cur_b1 = start ? CODE_DATA_I[15:8] : b1_r;
	assign cur_b2 = start ? CODE_DATA_I[23:16] : b2_r;
	assign done = (cnt_r == cur_cyc - 3'h1); // [RULE23]
	assign ri_val = rn_r[{2'h0, cur_idx[0]}];
	assign rn_val = rn_r[cur_idx];

	// Sequencing: one instruction at a time, no overlap
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_r <= ST_DECODE;
			cnt_r <= 3'h0;
		end else if (done) begin
			state_r <= ST_DECODE; // [RULE23]
			cnt_r <= 3'h0;
		end else begin
			state_r <= ST_EXEC;
			cnt_r <= cnt_r + 3'h1;
		end
	end

	// Latch the decoded instruction and its operand bytes
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			form_r <= F_BAD;
			idx_r <= 3'h0;
			len_r <= BAD_LEN;
			cyc_r <= BAD_CYC;
			b1_r <= 8'h00;
			b2_r <= 8'h00;
		end else if (start) begin
			form_r <= dec_form;
			idx_r <= dec_idx;
			len_r <= dec_len;
			cyc_r <= dec_cyc;
			b1_r <= CODE_DATA_I[15:8];
			b2_r <= CODE_DATA_I[23:16];
		end
	end

	// Internal RAM: reads issue in the first cycle, writes in the last
	always_comb begin
		ram_re = 1'b0;
		ram_raddr = cur_b1;
		ram_we = 1'b0;
		ram_waddr = cur_b1;
		ram_wdata = acc_r;
		case (cur_form)
			F_A_DIR, F_RN_DIR, F_PUSH: begin
				ram_re = start;
			end
			F_A_IND: begin
				ram_re = start;
				ram_raddr = ri_val;
			end
			F_DIR_A: begin
				ram_we = done; // [RULE8]
			end
			F_DIR_RN: begin
				ram_we = done; // [RULE9]
				ram_wdata = rn_val;
			end
			F_DIR_DIR: begin
				ram_re = start;
				ram_we = done; // [RULE10]
				ram_waddr = cur_b2;
				ram_wdata = ram_rdata;
			end
			F_DIR_IND: begin
				ram_re = start;
				ram_raddr = ri_val;
				ram_we = done; // [RULE11]
				ram_wdata = ram_rdata;
			end
			F_DIR_IMM: begin
				ram_we = done; // [RULE12]
				ram_wdata = cur_b2;
			end
			F_IND_A: begin
				ram_we = done; // [RULE13]
				ram_waddr = ri_val;
			end
			F_IND_DIR: begin
				ram_re = start;
				ram_we = done; // [RULE14]
				ram_waddr = ri_val;
				ram_wdata = ram_rdata;
			end
			F_IND_IMM: begin
				ram_we = done; // [RULE15]
				ram_waddr = ri_val;
				ram_wdata = cur_b1;
			end
			F_POP: begin
				ram_re = start;
				ram_raddr = sp_r; // [RULE24]
				ram_we = done; // [RULE20]
				ram_wdata = ram_rdata;
			end
			F_XCH_DIR: begin
				ram_re = start;
				ram_we = done; // [RULE21]
			end
			F_XCH_IND: begin
				ram_re = start;
				ram_raddr = ri_val;
				ram_we = done;
				ram_waddr = ri_val;
			end
			F_NIBBLE_SWAP_WITH_ACC: begin
				ram_re = start;
				ram_raddr = ri_val;
				ram_we = done;
				ram_waddr = ri_val;
				ram_wdata = {ram_rdata[7:4], acc_r[3:0]}; // [RULE22]
			end
			default: begin
				ram_re = 1'b0;
			end
		endcase
		// Push writes above the current top, after the increment
		if (cur_form == F_PUSH) begin
			ram_we = done; // [RULE20]
			ram_waddr = sp_r + 8'h01; // [RULE24]
			ram_wdata = ram_rdata;
		end
	end

	// Accumulator source selection
	always_comb begin
		acc_we = done;
		acc_nxt = acc_r;
		case (cur_form)
			F_A_RN: acc_nxt = rn_val; // [RULE1]
			F_A_DIR: acc_nxt = ram_rdata; // [RULE2]
			F_A_IND: acc_nxt = ram_rdata; // [RULE3]
			F_A_IMM: acc_nxt = cur_b1; // [RULE4]
			F_PROGRAM_MEMORY_FETCH_SIXTEEN_BIT_POINTER, F_PROGRAM_MEMORY_FETCH_PC: acc_nxt = CODE_DATA_I[7:0]; // [RULE17]
			F_XRD_RI, F_XRD_SIXTEEN_BIT_POINTER: acc_nxt = XDATA_RDATA_I; // [RULE18]
			F_XCH_RN: acc_nxt = rn_val; // [RULE21]
			F_XCH_DIR, F_XCH_IND: acc_nxt = ram_rdata;
			F_NIBBLE_SWAP_WITH_ACC: acc_nxt = {acc_r[7:4], ram_rdata[3:0]}; // [RULE22]
			default: acc_we = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			acc_r <= ACC_RESET;
		end else if (acc_we) begin
			acc_r <= acc_nxt;
		end
	end

	// Bank register source selection
	always_comb begin
		rn_we = done;
		rn_nxt = acc_r;
		case (cur_form)
			F_RN_A: rn_nxt = acc_r; // [RULE5]
			F_RN_DIR: rn_nxt = ram_rdata; // [RULE6]
			F_RN_IMM: rn_nxt = cur_b1; // [RULE7]
			F_XCH_RN: rn_nxt = acc_r; // [RULE21]
			default: rn_we = 1'b0;
		endcase
	end

	// One bank register per iteration, written only by its own index
	for (genvar g = 0; g < NUM_BANK; g++) begin : g_bank
		always_ff @(posedge CLK_I or posedge RST_I) begin
			if (RST_I) begin
				rn_r[g] <= 8'h00;
			end else if (rn_we && (cur_idx == 3'(g))) begin
				rn_r[g] <= rn_nxt;
			end
		end
	end

	// Sixteen-bit pointer, high byte first in the encoding
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sixteen_bit_pointer_r <= SIXTEEN_BIT_POINTER_RESET;
		end else if (done && (cur_form == F_SIXTEEN_BIT_POINTER_IMM)) begin
			sixteen_bit_pointer_r <= {cur_b1, cur_b2}; // [RULE16]
		end
	end

	// Stack pointer moves only when the instruction ends
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sp_r <= SP_RESET;
		end else if (done && (cur_form == F_PUSH)) begin
			sp_r <= sp_r + 8'h01; // [RULE24]
		end else if (done && (cur_form == F_POP)) begin
			sp_r <= sp_r - 8'h01; // [RULE24]
		end
	end

	// Instruction pointer steps by the instruction length
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pc_r <= PC_RESET;
		end else if (done) begin
			pc_r <= pc_r + {14'h0, cur_len}; // [RULE23]
		end
	end

	// Code address: the table lookup borrows the fetch port until the end
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			code_addr_r <= PC_RESET;
		end else if (done) begin
			code_addr_r <= pc_r + {14'h0, cur_len};
		end else if (start && (cur_form == F_PROGRAM_MEMORY_FETCH_SIXTEEN_BIT_POINTER)) begin
			code_addr_r <= sixteen_bit_pointer_r + {8'h00, acc_r}; // [RULE17]
		end else if (start && (cur_form == F_PROGRAM_MEMORY_FETCH_PC)) begin
			code_addr_r <= pc_r + 16'h0001 + {8'h00, acc_r}; // [RULE17]
		end
	end

	// External address and write data are set up early and held
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			xaddr_r <= 16'h0000;
			xwdata_r <= 8'h00;
		end else if (start) begin
			xwdata_r <= acc_r;
			if (cur_form inside {F_XRD_RI, F_XWR_RI}) begin
				xaddr_r <= {XPAGE, ri_val}; // [RULE18] [RULE19]
			end else begin
				xaddr_r <= sixteen_bit_pointer_r;
			end
		end
	end

	// Strobes fall in the last cycle only, so the address has settled
	assign XDATA_RE_O = done && (cur_form inside {F_XRD_RI, F_XRD_SIXTEEN_BIT_POINTER}); // [RULE18]
	assign XDATA_WE_O = done && (cur_form inside {F_XWR_RI, F_XWR_SIXTEEN_BIT_POINTER}); // [RULE19]
	assign XDATA_ADDR_O = xaddr_r;
	assign XDATA_WDATA_O = xwdata_r;
	assign CODE_ADDR_O = code_addr_r;
	assign ACC_O = acc_r;
	assign SIXTEEN_BIT_POINTER_O = sixteen_bit_pointer_r;
	assign SP_O = sp_r;
	assign PC_O = pc_r;
	assign INSTR_DONE_O = done;
	assign ILLEGAL_O = start && !dec_legal;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	a_one_cycle: assert property ( // [RULE1] [RULE5]
		start && (dec_form inside {F_A_RN, F_RN_A}) |-> INSTR_DONE_O
	) else $error("one-cycle transfer overran");

	a_two_cycle: assert property ( // [RULE2] [RULE3] [RULE4] [RULE7] [RULE8] [RULE9]
		start && (dec_form inside {F_A_DIR, F_A_IND, F_A_IMM, F_RN_IMM, F_DIR_A,
			F_DIR_RN, F_IND_A, F_IND_IMM, F_POP, F_XCH_RN})
		|-> !INSTR_DONE_O ##1 INSTR_DONE_O
	) else $error("two-cycle transfer wrong length");

	a_three_cycle: assert property ( // [RULE6] [RULE10] [RULE11] [RULE12] [RULE14]
		start && (dec_form inside {F_RN_DIR, F_DIR_DIR, F_DIR_IND, F_DIR_IMM,
			F_IND_DIR, F_SIXTEEN_BIT_POINTER_IMM, F_XRD_SIXTEEN_BIT_POINTER, F_PUSH, F_XCH_DIR, F_XCH_IND, F_NIBBLE_SWAP_WITH_ACC})
		|-> !INSTR_DONE_O [*2] ##1 INSTR_DONE_O
	) else $error("three-cycle transfer wrong length");

	a_four_cycle: assert property ( // [RULE17] [RULE18] [RULE19]
		start && (dec_form inside {F_PROGRAM_MEMORY_FETCH_PC, F_XRD_RI, F_XWR_SIXTEEN_BIT_POINTER})
		|-> !INSTR_DONE_O [*3] ##1 INSTR_DONE_O
	) else $error("four-cycle transfer wrong length");

	a_five_cycle: assert property ( // [RULE17] [RULE19]
		start && (dec_form inside {F_PROGRAM_MEMORY_FETCH_SIXTEEN_BIT_POINTER, F_XWR_RI})
		|-> !INSTR_DONE_O [*4] ##1 INSTR_DONE_O
	) else $error("five-cycle transfer wrong length");

	a_len_one: assert property ( // [RULE13] [RULE3] [RULE21] [RULE22]
		INSTR_DONE_O && (cur_form inside {F_A_RN, F_A_IND, F_RN_A, F_IND_A,
			F_PROGRAM_MEMORY_FETCH_SIXTEEN_BIT_POINTER, F_XWR_RI, F_XCH_IND, F_NIBBLE_SWAP_WITH_ACC})
		|=> PC_O == $past(PC_O) + 16'h0001
	) else $error("one-byte transfer moved pc wrongly");

	a_len_three: assert property ( // [RULE10] [RULE12] [RULE16]
		INSTR_DONE_O && (cur_form inside {F_DIR_DIR, F_DIR_IMM, F_SIXTEEN_BIT_POINTER_IMM})
		|=> PC_O == $past(PC_O) + 16'h0003
	) else $error("three-byte transfer moved pc wrongly");

	a_nibble_keep: assert property ( // [RULE22]
		INSTR_DONE_O && (cur_form == F_NIBBLE_SWAP_WITH_ACC)
		|=> ACC_O[7:4] == $past(ACC_O[7:4]) && ACC_O[3:0] == $past(ram_rdata[3:0])
	) else $error("nibble swap touched the high digit");

	a_push_order: assert property ( // [RULE24] [RULE20]
		INSTR_DONE_O && (cur_form == F_PUSH)
		|-> ram_we && ram_waddr == SP_O + 8'h01 ##1 SP_O == $past(SP_O) + 8'h01
	) else $error("push did not write above the old top");

	a_xwrite_late: assert property ( // [RULE23] [RULE19]
		XDATA_WE_O |-> INSTR_DONE_O ##1 start
	) else $error("external write not in the final cycle");
endmodule : dtx_core

// ===== dtx_decode.sv
// Opcode decoder: form, register index, length and cycle count
`timescale 1ns/1ns
module dtx_decode (
	// Opcode in
	input wire logic [7:0] opcode_i,
	// Decoded fields
	output dtx_pkg::dtx_form_t form_o,
	output logic [2:0] idx_o,
	output logic [1:0] len_o,
	output logic [2:0] cyc_o,
	output logic legal_o
);
	import dtx_pkg::*;

	always_comb begin
		idx_o = opcode_i[2:0];
		legal_o = (int'(opcode_i[7:3]) < NUM_FORMS);
		if (legal_o) begin
			form_o = dtx_form_t'(opcode_i[7:3]);
			len_o = FORM_LEN[opcode_i[7:3]];
			cyc_o = FORM_CYC[opcode_i[7:3]];
		end else begin
			form_o = F_BAD;
			len_o = BAD_LEN;
			cyc_o = BAD_CYC;
		end
	end
endmodule : dtx_decode

// ===== dtx_mem_model.sv
// Code and external data memories facing the data transfer core
`timescale 1ns/1ns
module dtx_mem_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Code memory
	input wire logic [15:0] code_addr_i,
	output logic [23:0] code_data_o,
	// External data memory
	input wire logic [15:0] xaddr_i,
	input wire logic [7:0] xwdata_i,
	input wire logic xwe_i,
	input wire logic xre_i,
	output logic [7:0] xrdata_o
);
	logic [7:0] code_mem [65536];
	logic [7:0] xmem [65536];
	logic [7:0] last_r;

	// Pattern fill so a table fetch from any address has a known answer
	initial begin
		for (int i = 0; i < 65536; i++) begin
			code_mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
			xmem[i] = 8'h00;
		end
		last_r = 8'h00;
	end

	// Three code bytes answer in the same cycle, wrapping at the top of the space
	assign code_data_o = {code_mem[code_addr_i + 16'h2], code_mem[code_addr_i + 16'h1],
		code_mem[code_addr_i]};

	// Outside a read strobe the bus is released; show the inverse of the last value
	assign xrdata_o = xre_i ? xmem[xaddr_i] : ~last_r;

	always @(posedge clk_i) begin
		if (!rst_i && xwe_i) begin
			xmem[xaddr_i] <= xwdata_i;
		end
		if (!rst_i && xre_i) begin
			last_r <= xmem[xaddr_i];
		end
	end
endmodule : dtx_mem_model

// ===== dtx_pkg.sv
// Shared constants and types for the data transfer execution unit
package dtx_pkg;
	// Instruction forms; the opcode carries the form in bits 7:3
	// and the bank_register index in bits 2:0
	typedef enum logic [4:0] {
		F_A_RN, F_A_DIR, F_A_IND, F_A_IMM,
		F_RN_A, F_RN_DIR, F_RN_IMM,
		F_DIR_A, F_DIR_RN, F_DIR_DIR, F_DIR_IND, F_DIR_IMM,
		F_IND_A, F_IND_DIR, F_IND_IMM,
		F_SIXTEEN_BIT_POINTER_IMM, F_PROGRAM_MEMORY_FETCH_SIXTEEN_BIT_POINTER, F_PROGRAM_MEMORY_FETCH_PC,
		F_XRD_RI, F_XRD_SIXTEEN_BIT_POINTER, F_XWR_RI, F_XWR_SIXTEEN_BIT_POINTER,
		F_PUSH, F_POP,
		F_XCH_RN, F_XCH_DIR, F_XCH_IND, F_NIBBLE_SWAP_WITH_ACC,
		F_BAD
	} dtx_form_t;

	typedef enum {ST_DECODE, ST_EXEC} dtx_state_t;

	localparam int NUM_FORMS = 28;
	localparam int NUM_BANK = 8;
	localparam int RAM_DEPTH = 256;

	// Instruction length in bytes, one entry per form
	localparam logic [1:0] FORM_LEN [NUM_FORMS] = '{
		2'h1, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2, 2'h2,
		2'h2, 2'h2, 2'h3, 2'h2, 2'h3, 2'h1, 2'h2, 2'h2,
		2'h3, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1,
		2'h2, 2'h2, 2'h1, 2'h2, 2'h1, 2'h1};

	// Execution cycles, one entry per form
	localparam logic [2:0] FORM_CYC [NUM_FORMS] = '{
		3'h1, 3'h2, 3'h2, 3'h2, 3'h1, 3'h3, 3'h2,
		3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h2, 3'h3, 3'h2,
		3'h3, 3'h5, 3'h4, 3'h4, 3'h3, 3'h5, 3'h4,
		3'h3, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3};

	// Unknown opcodes are skipped as one byte in one cycle
	localparam logic [1:0] BAD_LEN = 2'h1;
	localparam logic [2:0] BAD_CYC = 3'h1;

	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] SP_RESET = 8'h07;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [15:0] SIXTEEN_BIT_POINTER_RESET = 16'h0000;
	localparam logic [7:0] XPAGE = 8'h00;
endpackage : dtx_pkg

// ===== dtx_ram.sv
// Internal RAM, 256 bytes, registered read port and one write port
`timescale 1ns/1ns
module dtx_ram (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Read port
	input wire logic re_i,
	input wire logic [7:0] raddr_i,
	output logic [7:0] rdata_o,
	// Write port
	input wire logic we_i,
	input wire logic [7:0] waddr_i,
	input wire logic [7:0] wdata_i
);
	import dtx_pkg::*;

	logic [7:0] mem [RAM_DEPTH];

	// Contents are not reset, only the read register
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (re_i) begin
			rdata_o <= mem[raddr_i];
		end
	end
endmodule : dtx_ram
